// ===== src/csd_divider.sv
// Purpose: Programmable divider producing a one-cycle enable every N input ticks
// Assumes: Divisor zero is reserved and treated as one
// Notes: Used for both the reference and the input scaler
`timescale 1ns/1ns
`default_nettype none
module csd_divider #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic tick_in,
  input wire logic [W-1:0] divisor,
  // Result
  output logic tick_out
);
  logic [W-1:0] cnt_r;
  wire logic last_w = (cnt_r + W'(1) >= divisor);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_r <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && last_w;
      if (tick_in) begin
        cnt_r <= last_w ? '0 : cnt_r + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/csd_pkg.sv
// Purpose: Shared constants and types for the channel settle and scaler block
// Assumes: 16-bit register data on a plain strobe port
// Notes: Offsets are register indices on the plain port
package csd_pkg;
  localparam logic [7:0] CSD_OFF_CH1_SETTLE = 8'h11;
  localparam logic [7:0] CSD_OFF_CH2_SETTLE = 8'h12;
  localparam logic [7:0] CSD_OFF_CH3_SETTLE = 8'h13;
  localparam logic [7:0] CSD_OFF_CH0_SCALE = 8'h14;
  localparam logic [7:0] CSD_OFF_CONTROL = 8'h20;
  localparam logic [7:0] CSD_OFF_IRQ_STATUS = 8'h21;
  localparam logic [7:0] CSD_OFF_IRQ_MASK = 8'h22;
  localparam logic [7:0] CSD_OFF_STATE = 8'h23;
  localparam logic [15:0] CSD_RST_SETTLE = 16'h0000;
  localparam logic [15:0] CSD_RST_SCALE = 16'h0000;
  localparam logic [15:0] CSD_RST_CONTROL = 16'h0000;
  localparam logic [2:0] CSD_RST_IRQ = 3'h0;
  localparam int CSD_IN_SCALE_MSB = 15;
  localparam int CSD_IN_SCALE_LSB = 12;
  localparam int CSD_REF_SCALE_MSB = 9;
  localparam int CSD_REF_SCALE_LSB = 0;
  localparam int CSD_CTL_ACTIVE_LSB = 0;
  localparam int CSD_CTL_CHAN_LSB = 2;
  localparam int CSD_CTL_AMP_EN_BIT = 4;
  localparam int CSD_IRQ_DONE_BIT = 0;
  localparam int CSD_IRQ_AMP_BIT = 1;
  localparam int CSD_IRQ_START_BIT = 2;
  localparam logic [15:0] CSD_SETTLE_SHORT_LIMIT = 16'h0001;
  localparam logic [19:0] CSD_SETTLE_SHORT_TICKS = 20'h00020;
  localparam int CSD_SETTLE_MULT_SHIFT = 4;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } csd_bus_req_t;
  typedef enum logic [1:0] {CSD_IDLE, CSD_SETTLE, CSD_CONVERT} csd_state_t;
endpackage

// ===== src/csd_top.sv
// Purpose: Settling timer and channel 0 clock scalers of the sensor converter
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Settle timing runs on the channel reference tick from the scaler
`timescale 1ns/1ns
`default_nettype none

module csd_top
  import csd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Sensor side
  input wire logic sensor_osc_tick,
  input wire logic amp_settled,
  // Results
  output logic ref_tick,
  output logic in_tick,
  output logic settle_done,
  output logic conv_active,
  output logic amp_error,
  output logic irq
);
  csd_bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic [15:0] settle_r [1:3];
  logic [15:0] scale_r;
  logic [15:0] ctl_r;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  csd_state_t state_r;
  logic [19:0] cnt_r;
  logic [19:0] target_r;
  logic [1:0] chan_r;

  function automatic logic hit(input csd_bus_req_t r, input logic [7:0] off);
    return r.addr == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  wire logic wr_scale = req.wr && hit(req, CSD_OFF_CH0_SCALE);
  wire logic wr_ctl = req.wr && hit(req, CSD_OFF_CONTROL);
  wire logic wr_mask = req.wr && hit(req, CSD_OFF_IRQ_MASK);
  wire logic rd_stat = req.rd && hit(req, CSD_OFF_IRQ_STATUS);

  genvar g;
  generate
    for (g = 1; g <= 3; g++) begin : g_settle
      wire logic wr_set = req.wr && hit(req, CSD_OFF_CH1_SETTLE + 8'(g - 1));
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          settle_r[g] <= CSD_RST_SETTLE;
        end else if (wr_set) begin
          settle_r[g] <= req.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      scale_r <= CSD_RST_SCALE;
      ctl_r <= CSD_RST_CONTROL;
      mask_r <= CSD_RST_IRQ;
    end else begin
      if (wr_scale) begin
        scale_r <= req.wdata;
      end
      if (wr_ctl) begin
        ctl_r <= req.wdata;
      end
      if (wr_mask) begin
        mask_r <= req.wdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scalers
  wire logic [3:0] in_div = scale_r[CSD_IN_SCALE_MSB:CSD_IN_SCALE_LSB];
  wire logic [9:0] ref_div = scale_r[CSD_REF_SCALE_MSB:CSD_REF_SCALE_LSB];

  csd_divider #(.W(10)) u_ref_div (
    .mclk(mclk),
    .rstn(rstn),
    .tick_in(1'b1),
    .divisor(ref_div),
    .tick_out(ref_tick)
  );

  csd_divider #(.W(4)) u_in_div (
    .mclk(mclk),
    .rstn(rstn),
    .tick_in(sensor_osc_tick),
    .divisor(in_div),
    .tick_out(in_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Settling sequencer
  wire logic ch_active = ctl_r[CSD_CTL_ACTIVE_LSB];
  wire logic [1:0] ch_sel = ctl_r[CSD_CTL_CHAN_LSB +: 2];
  wire logic amp_en = ctl_r[CSD_CTL_AMP_EN_BIT];
  wire logic [15:0] sel_count = (ch_sel == 2'h0) ? 16'h0000 : settle_r[ch_sel];
  wire logic [19:0] settle_ticks = (sel_count <= CSD_SETTLE_SHORT_LIMIT) ?
    CSD_SETTLE_SHORT_TICKS : {sel_count, 4'h0};
  wire logic start_w = (state_r == CSD_IDLE) && ch_active && (ch_sel != 2'h0);
  wire logic done_w = (state_r == CSD_SETTLE) && ref_tick && (cnt_r + 20'h1 == target_r);
  wire logic amp_err_w = done_w && amp_en && !amp_settled;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r <= CSD_IDLE;
      cnt_r <= '0;
      target_r <= '0;
      chan_r <= '0;
    end else begin
      unique case (state_r)
        CSD_IDLE: begin
          cnt_r <= '0;
          if (start_w) begin
            target_r <= settle_ticks;
            chan_r <= ch_sel;
            state_r <= CSD_SETTLE;
          end
        end
        CSD_SETTLE: begin
          if (!ch_active) begin
            state_r <= CSD_IDLE;
          end else if (done_w) begin
            state_r <= CSD_CONVERT;
          end else if (ref_tick) begin
            cnt_r <= cnt_r + 20'h1;
          end
        end
        CSD_CONVERT: begin
          if (!ch_active) begin
            state_r <= CSD_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, events and readback
  wire logic [2:0] ev_w = {start_w, amp_err_w, done_w};
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (hit(req, CSD_OFF_CH1_SETTLE)) rd_mux = settle_r[1];
    if (hit(req, CSD_OFF_CH2_SETTLE)) rd_mux = settle_r[2];
    if (hit(req, CSD_OFF_CH3_SETTLE)) rd_mux = settle_r[3];
    if (hit(req, CSD_OFF_CH0_SCALE)) rd_mux = scale_r;
    if (hit(req, CSD_OFF_CONTROL)) rd_mux = ctl_r;
    if (hit(req, CSD_OFF_IRQ_STATUS)) rd_mux = {13'h0000, stat_r};
    if (hit(req, CSD_OFF_IRQ_MASK)) rd_mux = {13'h0000, mask_r};
    if (hit(req, CSD_OFF_STATE)) rd_mux = {12'h000, chan_r, 2'(state_r)};
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
      stat_r <= CSD_RST_IRQ;
      settle_done <= 1'b0;
      amp_error <= 1'b0;
      conv_active <= 1'b0;
      irq <= 1'b0;
    end else begin
      reg_rdata <= req.rd ? rd_mux : 16'h0000;
      // Set wins over the read clear
      stat_r <= (rd_stat ? 3'h0 : stat_r) | ev_w;
      settle_done <= done_w;
      amp_error <= amp_err_w;
      conv_active <= (state_r == CSD_CONVERT) || done_w;
      irq <= |(((rd_stat ? 3'h0 : stat_r) | ev_w) & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_settling;
    state_r == CSD_SETTLE;
  endsequence

  done_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
    done_w |=> settle_done ##1 !settle_done)
    else $error("settle done not a single pulse");
  count_exact_a: assert property (@(posedge mclk) disable iff (!rstn)
    done_w |-> (cnt_r + 20'h1 == target_r))
    else $error("settle ended early");
  short_floor_a: assert property (@(posedge mclk) disable iff (!rstn)
    start_w && sel_count <= 16'h0001 |=> target_r == 20'h00020)
    else $error("short settle not 32");
  mult_sixteen_a: assert property (@(posedge mclk) disable iff (!rstn)
    start_w && sel_count > 16'h0001 |=> target_r == {$past(sel_count), 4'h0})
    else $error("settle not sixteen times");
  amp_err_a: assert property (@(posedge mclk) disable iff (!rstn)
    done_w && amp_en && !amp_settled |=> amp_error && stat_r[1])
    else $error("amplitude error missed");
  no_err_a: assert property (@(posedge mclk) disable iff (!rstn)
    !amp_en |=> !amp_error)
    else $error("error raised while disabled");
  ref_rate_a: assert property (@(posedge mclk) disable iff (!rstn)
    ref_tick && ref_div == 10'h002 && $stable(ref_div) |=> !ref_tick)
    else $error("reference divide by two wrong");
  in_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
    !$past(sensor_osc_tick) |-> !in_tick)
    else $error("input tick without sensor tick");
  settle_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    s_settling and !done_w |=> !conv_active)
    else $error("conversion before settle end");
endmodule
`default_nettype wire

// ===== tb/csd_sensor_model.sv
// Purpose: Behavioural resonant sensor beside the converter
// Assumes: One oscillation pulse every period mclk cycles
// Notes: Amplitude level follows the bench request one cycle late
`timescale 1ns/1ns
`default_nettype none
module csd_sensor_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control from bench
  input wire logic [7:0] period,
  input wire logic settle_req,
  // Sensor outputs
  output logic osc_tick,
  output logic amp_ok
);
  logic [7:0] cnt_r;
  logic wrap;
  assign wrap = cnt_r == period - 8'h01;
  ////////////////////////////////////////////////////////////////
  // fast oscillation rate
  always_ff @(posedge mclk) begin
    if (!rstn || wrap) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
    osc_tick <= rstn && wrap;
    amp_ok <= settle_req;
  end
endmodule
`default_nettype wire

// ===== tb/csd_top_tb.sv
// Purpose: Self-checking bench for the settle timer and scalers
// Assumes: Register read data one cycle after the strobe
// Notes: Reference scaler kept small so settle runs stay short
`timescale 1ns/1ns
`default_nettype none
module csd_top_tb;
  import csd_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic settle_req = 1'b1;
  logic [15:0] reg_rdata;
  logic sensor_osc_tick, amp_settled, ref_tick, in_tick;
  logic settle_done, conv_active, amp_error, irq;
  int fail_count = 0;
  int total_checks = 0;
  always #2 mclk = ~mclk;
  csd_sensor_model u_csd_sensor_model (.mclk(mclk), .rstn(rstn), .period(8'h05),
    .settle_req(settle_req), .osc_tick(sensor_osc_tick), .amp_ok(amp_settled));
  csd_top u_csd_top (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sensor_osc_tick(sensor_osc_tick), .amp_settled(amp_settled), .ref_tick(ref_tick),
    .in_tick(in_tick), .settle_done(settle_done), .conv_active(conv_active),
    .amp_error(amp_error), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 4000) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  // First gap after a scaler write may be short, so the first two gaps are skipped and only the third is checked
  task automatic gap(input bit sel, input int exp);
    int n;
    for (int i = 0; i < 3; i++) begin
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while ((sel ? in_tick : ref_tick) !== 1'b1 && n < 4000);
      tmo(n);
    end
    chk(16'(n), 16'(exp));
  endtask
  task automatic settle(input logic [1:0] ch, input logic [15:0] cnt, input logic en,
      input logic ok, input int exp);
    int n;
    int k;
    n = 0;
    k = 0;
    settle_req <= ok;
    wr(CSD_OFF_CH1_SETTLE + 8'(ch) - 8'h01, cnt);
    wr(CSD_OFF_CONTROL, {11'h000, en, ch, 2'b01});
    @(posedge mclk);
    do begin
      @(negedge mclk);
      k++;
      if (settle_done !== 1'b1) n += int'(ref_tick);
    end while (settle_done !== 1'b1 && k < 4000);
    tmo(k);
    chk(16'(n), 16'(exp));
    chk({15'h0000, amp_error}, {15'h0000, en & ~ok});
    @(negedge mclk);
    chk({15'h0000, conv_active}, 16'h0001);
    rd(CSD_OFF_STATE, {12'h000, ch, 2'h2});
    wr(CSD_OFF_CONTROL, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 17; a <= 20; a++) rd(8'(a), 16'h0000);
    wr(8'h30, 16'hffff);
    rd(8'h30, 16'h0000);
    wr(CSD_OFF_CH0_SCALE, 16'h3003);
    rd(CSD_OFF_CH0_SCALE, 16'h3003);
    gap(1'b0, 3);
    gap(1'b1, 15);
    wr(CSD_OFF_CH0_SCALE, 16'h2002);
    gap(1'b0, 2);
    gap(1'b1, 10);
    settle(2'd1, 16'h0000, 1'b0, 1'b0, 32);
    settle(2'd2, 16'h0001, 1'b1, 1'b1, 32);
    settle(2'd3, 16'h0002, 1'b1, 1'b0, 32);
    @(negedge mclk);
    chk({15'h0000, irq}, 16'h0000);
    wr(CSD_OFF_IRQ_MASK, 16'h0002);
    settle(2'd1, 16'h0003, 1'b1, 1'b0, 48);
    @(negedge mclk);
    chk({15'h0000, irq}, 16'h0001);
    rd(CSD_OFF_IRQ_STATUS, 16'h0007);
    repeat (2) @(negedge mclk);
    chk({15'h0000, irq}, 16'h0000);
    rd(CSD_OFF_IRQ_STATUS, 16'h0000);
    rd(CSD_OFF_CH1_SETTLE, 16'h0003);
    summarize();
  end
endmodule
`default_nettype wire
